// >>> design/tpo_pkg.sv
// Shared constants and types of the time-proportioning output block
package tpo_pkg;
   // ********************************
   // Timing
   // ********************************
   localparam int CLOCK_MHZ = 200;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = TICK_MS * 1000 * CLOCK_MHZ;
   localparam int TIME_W = 24;
   localparam int DEMAND_W = 7;
   localparam int PERIOD_W = 10;
   localparam int PULSE_W = 14;
   localparam int TICKS_PER_S = 1000 / TICK_MS;
   localparam int PERIOD_MAX_S = 600;
   localparam int MIN_RELAY_MS = 1000;
   localparam int MIN_LOGIC_MS = 50;
   localparam logic [TIME_W-1:0] MIN_RELAY_TICKS =
      TIME_W'((MIN_RELAY_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] MIN_LOGIC_TICKS =
      TIME_W'((MIN_LOGIC_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] PULSE_MAX_TICKS = 24'h003A98;
   localparam logic [DEMAND_W-1:0] DEMAND_FULL = 7'h64;
   localparam logic [DEMAND_W-1:0] DEMAND_HALF = 7'h32;
   localparam int RIPPLE_FACTOR = 4;
   // ********************************
   // Register map (byte offsets)
   // ********************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_PULSE = 4'h4;
   localparam logic [3:0] ADDR_DEMAND = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   localparam int CTRL_POL_BIT = 16;
   localparam int CTRL_LOGIC_BIT = 17;
   localparam int CTRL_OUT_BIT = 18;
   localparam int STAT_DRIVE_BIT = 0;
   localparam int STAT_PIN_BIT = 1;
   localparam int STAT_INPUT_BIT = 2;
   localparam int STAT_RIPPLE_BIT = 3;
   localparam int STAT_PERIOD_LSB = 8;
   localparam logic [PERIOD_W-1:0] PERIOD_RST = 10'h000;
   localparam logic [PULSE_W-1:0] PULSE_RST = 14'h0000;
   localparam logic [DEMAND_W-1:0] DEMAND_RST = 7'h00;
   // ********************************
   // Cycle sequencer states
   // ********************************
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_DIV_A = 2'b01,
      S_DIV_B = 2'b11,
      S_RUN = 2'b10
   } tpo_state_t;
endpackage

// >>> design/tpo_div.sv
// Serial restoring divider used to plan each output cycle
`timescale 1ns/10ps
module tpo_div #(
   parameter int W = 24,
   parameter int DW = 7
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic start,
   input wire logic [W-1:0] num,
   input wire logic [DW-1:0] den,
   output logic done,
   output logic [W-1:0] quot
);
   localparam int CW = $clog2(W + 1);

   generate
      if (DW < 1 || W < DW) begin : g_bad
         $error("tpo_div: unsupported widths");
      end
   endgenerate

   typedef struct packed {
      logic [W-1:0] quo;
      logic [DW:0] rem;
      logic [DW-1:0] den;
      logic [CW-1:0] cnt;
      logic busy;
      logic done;
   } tpo_div_t;

   tpo_div_t st;
   tpo_div_t next_st;
   logic [DW:0] trial;

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      trial = {st.rem[DW-1:0], st.quo[W-1]};
      if (st.busy) begin
         // A zero divisor yields all ones and still finishes
         if (trial >= {1'b0, st.den}) begin
            next_st.rem = trial - {1'b0, st.den};
            next_st.quo = {st.quo[W-2:0], 1'b1};
         end else begin
            next_st.rem = trial;
            next_st.quo = {st.quo[W-2:0], 1'b0};
         end
         next_st.cnt = st.cnt - 1'b1;
         if (st.cnt == CW'(1)) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end
      end else if (start) begin
         next_st.quo = num;
         next_st.rem = '0;
         next_st.den = den;
         next_st.cnt = CW'(W);
         next_st.busy = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;
   assign quot = st.quo;
endmodule

// >>> design/tpo_output.sv
// Time-proportioning output generator with Avalon-MM register slave
`timescale 1ns/10ps
// Function
// - Cycle-time setting spans 0 to 600 s; 0 selects automatic mode.
// - Setting 0 runs constant ripple, period recomputed from demand every cycle.
// - In constant ripple, half demand gives period of four least pulses.
// - In constant ripple, period grows as demand moves away from half.
// - Nonzero setting holds the period at the set value for steady demand.
// - Constant period stretches only enough to keep both pulses above least pulse.
// - Normal polarity: output off when the demand is off.
// - Inverted polarity: output off while the drive condition is active.
// - Digital input with normal polarity is active on a high pin.
// - Digital input with inverted polarity is active on a low pin.
// - Least pulse spaces every switching event; auto is 1 s relay, 0.05 s logic.
module tpo_output
   import tpo_pkg::*;
#(
   parameter int TICK_CYCLES = tpo_pkg::TICK_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic input_active
);
   import tpo_pkg::*;

   generate
      if (TICK_CYCLES < 1) begin : g_bad
         $error("tpo_output: TICK_CYCLES must be at least 1");
      end
   endgenerate

   // ********************************
   // State
   // ********************************
   typedef struct packed {
      logic [PERIOD_W-1:0] period_s;
      logic pol;
      logic hw_logic;
      logic is_out;
      logic [PULSE_W-1:0] pulse_set;
      logic [DEMAND_W-1:0] demand;
      logic [31:0] tick_cnt;
      tpo_state_t fsm;
      logic kick;
      logic ripple_l;
      logic [DEMAND_W-1:0] d_l;
      logic [TIME_W-1:0] t_l;
      logic [TIME_W-1:0] m_l;
      logic [TIME_W-1:0] qa;
      logic [TIME_W-1:0] on_t;
      logic [TIME_W-1:0] off_t;
      logic [TIME_W-1:0] phase_cnt;
      logic phase_on;
      logic drive;
      logic pin_out;
      logic pin_oe;
      logic input_active;
      logic waitrequest;
      logic [31:0] readdata;
   } tpo_regs_t;

   tpo_regs_t st;
   tpo_regs_t next_st;

   logic tick;
   logic div_done;
   logic [TIME_W-1:0] div_quot;
   logic [TIME_W-1:0] div_num;
   logic [DEMAND_W-1:0] div_den;
   logic [DEMAND_W-1:0] rest;
   logic [TIME_W-1:0] m_eff;
   logic [TIME_W-1:0] off_c;

   function automatic logic [TIME_W-1:0] mul(input logic [TIME_W-1:0] a,
                                             input logic [DEMAND_W-1:0] b);
      mul = TIME_W'(a * {{(TIME_W - DEMAND_W){1'b0}}, b});
   endfunction

   // Auto or clipped least pulse, in ticks
   function automatic logic [TIME_W-1:0] least_pulse(input logic [PULSE_W-1:0] set,
                                                     input logic logic_hw);
      logic [TIME_W-1:0] floor_t;
      logic [TIME_W-1:0] v;
      floor_t = logic_hw ? MIN_LOGIC_TICKS : MIN_RELAY_TICKS;
      v = {{(TIME_W - PULSE_W){1'b0}}, set};
      if (set == '0 || v < floor_t) begin
         least_pulse = floor_t;
      end else if (v > PULSE_MAX_TICKS) begin
         least_pulse = PULSE_MAX_TICKS;
      end else begin
         least_pulse = v;
      end
   endfunction

   tpo_div #(
      .W(TIME_W),
      .DW(DEMAND_W)
   ) u_div (
      .clock(clock),
      .resetn(resetn),
      .start(st.kick),
      .num(div_num),
      .den(div_den),
      .done(div_done),
      .quot(div_quot)
   );

   // ********************************
   // Combinational next state
   // ********************************
   always_comb begin
      next_st = st;
      next_st.kick = 1'b0;
      tick = (st.tick_cnt == 32'(TICK_CYCLES - 1));
      next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;
      rest = DEMAND_FULL - st.d_l;
      m_eff = least_pulse(st.pulse_set, st.hw_logic);
      off_c = st.t_l - st.qa;

      // Divider operands per planning step
      if (st.fsm == S_DIV_A) begin
         if (st.ripple_l) begin
            div_num = mul(st.m_l, DEMAND_FULL);
            div_den = rest;
         end else begin
            div_num = mul(st.t_l, st.d_l);
            div_den = DEMAND_FULL;
         end
      end else begin
         if (st.ripple_l) begin
            div_num = mul(st.m_l, DEMAND_FULL);
            div_den = st.d_l;
         end else if (st.d_l < DEMAND_HALF) begin
            div_num = mul(st.m_l, rest);
            div_den = st.d_l;
         end else begin
            div_num = mul(st.m_l, st.d_l);
            div_den = rest;
         end
      end

      // Avalon slave: one wait cycle, answer on the next edge
      next_st.waitrequest = !((read || write) && st.waitrequest);
      if (read && st.waitrequest) begin
         next_st.readdata = 32'h0;
         case (address)
            ADDR_CTRL: begin
               next_st.readdata[PERIOD_W-1:0] = st.period_s;
               next_st.readdata[CTRL_POL_BIT] = st.pol;
               next_st.readdata[CTRL_LOGIC_BIT] = st.hw_logic;
               next_st.readdata[CTRL_OUT_BIT] = st.is_out;
            end
            ADDR_PULSE: next_st.readdata[PULSE_W-1:0] = st.pulse_set;
            ADDR_DEMAND: next_st.readdata[DEMAND_W-1:0] = st.demand;
            ADDR_STATUS: begin
               next_st.readdata[STAT_DRIVE_BIT] = st.drive;
               next_st.readdata[STAT_PIN_BIT] = st.pin_out;
               next_st.readdata[STAT_INPUT_BIT] = st.input_active;
               next_st.readdata[STAT_RIPPLE_BIT] = st.ripple_l;
               next_st.readdata[STAT_PERIOD_LSB +: TIME_W] = st.on_t + st.off_t;
            end
            default: next_st.readdata = 32'h0;
         endcase
      end
      if (write && !st.waitrequest) begin
         case (address)
            ADDR_CTRL: begin
               // Out-of-range settings saturate at the top of the range
               if (writedata[PERIOD_W-1:0] > PERIOD_W'(PERIOD_MAX_S)) begin
                  next_st.period_s = PERIOD_W'(PERIOD_MAX_S);
               end else begin
                  next_st.period_s = writedata[PERIOD_W-1:0];
               end
               next_st.pol = writedata[CTRL_POL_BIT];
               next_st.hw_logic = writedata[CTRL_LOGIC_BIT];
               next_st.is_out = writedata[CTRL_OUT_BIT];
            end
            ADDR_PULSE: next_st.pulse_set = writedata[PULSE_W-1:0];
            ADDR_DEMAND: begin
               if (writedata[DEMAND_W-1:0] > DEMAND_FULL) begin
                  next_st.demand = DEMAND_FULL;
               end else begin
                  next_st.demand = writedata[DEMAND_W-1:0];
               end
            end
            default: next_st.demand = st.demand;
         endcase
      end

      // Cycle planner; period, least pulse and demand are sampled once per output cycle
      case (st.fsm)
         S_IDLE: begin
            next_st.ripple_l = (st.period_s == '0);
            next_st.t_l = mul({{(TIME_W - PERIOD_W){1'b0}}, st.period_s},
                              DEMAND_W'(TICKS_PER_S));
            next_st.m_l = m_eff;
            next_st.d_l = st.demand;
            next_st.kick = 1'b1;
            next_st.fsm = S_DIV_A;
         end
         S_DIV_A: begin
            if (div_done) begin
               next_st.qa = div_quot;
               next_st.kick = 1'b1;
               next_st.fsm = S_DIV_B;
            end
         end
         S_DIV_B: begin
            if (div_done) begin
               if (st.d_l == '0) begin
                  // Rest at off; recheck after one least pulse
                  next_st.on_t = '0;
                  next_st.off_t = st.m_l;
               end else if (st.d_l >= DEMAND_FULL) begin
                  next_st.on_t = st.m_l;
                  next_st.off_t = '0;
               end else if (st.ripple_l) begin
                  // on = m/(1-p), off = m/p: equal ripple at any demand
                  next_st.on_t = st.qa;
                  next_st.off_t = div_quot;
               end else if (st.d_l < DEMAND_HALF) begin
                  if (st.qa < st.m_l) begin
                     next_st.on_t = st.m_l;
                     next_st.off_t = div_quot;
                  end else begin
                     next_st.on_t = st.qa;
                     next_st.off_t = off_c;
                  end
               end else begin
                  if (off_c < st.m_l) begin
                     next_st.on_t = div_quot;
                     next_st.off_t = st.m_l;
                  end else begin
                     next_st.on_t = st.qa;
                     next_st.off_t = off_c;
                  end
               end
               if (st.d_l == '0) begin
                  next_st.phase_on = 1'b0;
                  next_st.phase_cnt = st.m_l;
                  next_st.drive = 1'b0;
               end else begin
                  next_st.phase_on = 1'b1;
                  next_st.phase_cnt = (st.d_l >= DEMAND_FULL) ? st.m_l :
                     (st.ripple_l ? st.qa :
                      ((st.d_l < DEMAND_HALF) ?
                       ((st.qa < st.m_l) ? st.m_l : st.qa) :
                       ((off_c < st.m_l) ? div_quot : st.qa)));
                  next_st.drive = 1'b1;
               end
               // Tick restarts here, so the first pulse is never cut short
               next_st.tick_cnt = '0;
               next_st.fsm = S_RUN;
            end
         end
         S_RUN: begin
            if (tick) begin
               if (st.phase_cnt > TIME_W'(1)) begin
                  next_st.phase_cnt = st.phase_cnt - TIME_W'(1);
               end else if (st.phase_on && st.off_t != '0) begin
                  next_st.phase_on = 1'b0;
                  next_st.phase_cnt = st.off_t;
                  next_st.drive = 1'b0;
               end else begin
                  next_st.fsm = S_IDLE;
               end
            end
         end
         default: next_st.fsm = S_IDLE;
      endcase

      // Pin: output drive with polarity, or sensed input
      next_st.pin_oe = st.is_out;
      next_st.pin_out = st.is_out & (st.drive ^ st.pol);
      next_st.input_active = !st.is_out & (pin_in ^ st.pol);
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.period_s <= PERIOD_RST;
         st.pulse_set <= PULSE_RST;
         st.demand <= DEMAND_RST;
         st.fsm <= S_IDLE;
         st.waitrequest <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign readdata = st.readdata;
   assign waitrequest = st.waitrequest;
   assign pin_out = st.pin_out;
   assign pin_oe = st.pin_oe;
   assign input_active = st.input_active;

   // ********************************
   // Assertions
   // ********************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   logic [TIME_W-1:0] gap;
   logic plan_done;
   assign plan_done = (st.fsm == S_DIV_B) && div_done;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gap <= '1;
      end else if (st.drive != next_st.drive) begin
         gap <= '0;
      end else if (tick && gap != '1) begin
         gap <= gap + TIME_W'(1);
      end
   end

   property p_period_range;
      st.period_s <= PERIOD_W'(PERIOD_MAX_S);
   endproperty
   a_period_range: assert property (p_period_range) else $error("period over range");

   property p_ripple_half;
      plan_done && st.ripple_l && st.d_l == DEMAND_HALF
         |=> st.on_t + st.off_t == mul(st.m_l, DEMAND_W'(RIPPLE_FACTOR));
   endproperty
   a_ripple_half: assert property (p_ripple_half) else $error("half period wrong");

   property p_ripple_wide;
      plan_done && st.ripple_l && st.d_l != '0 && st.d_l < DEMAND_FULL
         && (st.d_l <= 7'h19 || st.d_l >= 7'h4B)
         |=> st.on_t + st.off_t > mul(st.m_l, 7'h05);
   endproperty
   a_ripple_wide: assert property (p_ripple_wide) else $error("ripple not wider");

   property p_const_hold;
      plan_done && !st.ripple_l && st.d_l != '0 && st.d_l < DEMAND_FULL
         |=> st.on_t + st.off_t >= st.t_l;
   endproperty
   a_const_hold: assert property (p_const_hold) else $error("period shortened");

   property p_const_pulse;
      plan_done && !st.ripple_l && st.d_l != '0 && st.d_l < DEMAND_FULL
         |=> st.on_t >= st.m_l && st.off_t >= st.m_l;
   endproperty
   a_const_pulse: assert property (p_const_pulse) else $error("pulse too short");

   property p_out_pol;
      st.is_out ##1 st.is_out |-> st.pin_out == ($past(st.drive) ^ $past(st.pol));
   endproperty
   a_out_pol: assert property (p_out_pol) else $error("pin polarity wrong");

   property p_in_pol;
      !st.is_out |=> st.input_active == ($past(pin_in) ^ $past(st.pol)) && !st.pin_oe;
   endproperty
   a_in_pol: assert property (p_in_pol) else $error("input sense wrong");

   property p_switch_gap;
      $changed(st.drive) |-> $past(gap) >= MIN_LOGIC_TICKS - TIME_W'($past(tick));
   endproperty
   a_switch_gap: assert property (p_switch_gap) else $error("switching too close");
endmodule

// >>> dv/tpo_actuator.sv
// Switching actuator model on the far side of the output pin
`timescale 1ns/10ps
module tpo_actuator (
   input wire logic clock,
   input wire logic resetn,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic drive_en,
   input wire logic drive_level,
   output logic pin_in,
   output logic cycle_done,
   output int on_len,
   output int off_len
);
   logic last_level;
   logic prev_out;
   int run_len;
   // Released pin toggles, so a stale level never passes for a real one
   assign pin_in = pin_oe ? pin_out : (drive_en ? drive_level : ~last_level);
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         last_level <= 1'b0;
         prev_out <= 1'b0;
         run_len <= 0;
         cycle_done <= 1'b0;
         on_len <= 0;
         off_len <= 0;
      end else begin
         last_level <= pin_in;
         prev_out <= pin_out;
         cycle_done <= 1'b0;
         run_len <= run_len + 1;
         if (pin_oe && pin_out && !prev_out) begin
            off_len <= run_len;
            cycle_done <= 1'b1;
            run_len <= 1;
         end
         if (pin_oe && !pin_out && prev_out) begin
            on_len <= run_len;
            run_len <= 1;
         end
      end
   end
endmodule

// >>> dv/time_proportioning_output_bench.sv
// Self-checking bench for the time-proportioning output generator
`timescale 1ns/10ps
module time_proportioning_output_bench;
   import tpo_pkg::*;
   localparam int TK = 10;
   localparam int M = 5;
   typedef struct {int shift; logic [31:0] mask; logic [31:0] lo; logic [31:0] hi;} tpo_rd_t;
   typedef struct {int on_t; int off_t;} tpo_cyc_t;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic drive_en = 1'b0;
   logic drive_level = 1'b0;
   logic static_chk = 1'b0;
   logic [31:0] readdata;
   logic waitrequest, pin_in, pin_out, pin_oe, input_active, cycle_done;
   int on_len, off_len, d, pol, lvl;
   int err_count = 0;
   int checks_done = 0;
   int seed = 81;
   tpo_rd_t rd_q[$];
   tpo_cyc_t cyc_q[$];
   always #2.5 clock = ~clock;
   tpo_output #(.TICK_CYCLES(TK)) tpo_output_i (.clock(clock), .resetn(resetn),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .input_active(input_active));
   tpo_actuator tpo_actuator_i (.clock(clock), .resetn(resetn), .pin_out(pin_out),
      .pin_oe(pin_oe), .drive_en(drive_en), .drive_level(drive_level), .pin_in(pin_in),
      .cycle_done(cycle_done), .on_len(on_len), .off_len(off_len));
   // ********************************
   // Checking
   // ********************************
   task automatic fail(input string msg);
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask
   task automatic in_range(input string what, input logic [31:0] got, input int lo, input int hi);
      checks_done++;
      if ($isunknown(got) || got < lo || got > hi) begin
         fail($sformatf("%s got %0d want %0d..%0d", what, got, lo, hi));
      end
   endtask
   task automatic compare_read(input tpo_rd_t e, input logic [31:0] data);
      logic [31:0] f;
      f = (data >> e.shift) & e.mask;
      checks_done++;
      if (f !== e.lo && e.lo === e.hi) begin
         fail($sformatf("read got %0h want %0h", f, e.lo));
      end
      if (e.lo !== e.hi) begin
         in_range("read field", f, e.lo, e.hi);
      end
   endtask
   task automatic compare_cycle(input tpo_cyc_t e);
      in_range("on time", on_len, e.on_t * TK - TK, e.on_t * TK + TK);
      in_range("off time", off_len, e.off_t * TK - TK, e.off_t * TK + 8 * TK);
      in_range("on spacing", on_len, M * TK - TK, 32'h7FFFFFFF);
      in_range("off spacing", off_len, M * TK - TK, 32'h7FFFFFFF);
   endtask
   // Watcher: takes the oldest note whenever a result shows up
   always @(posedge clock) begin
      if (read === 1'b1 && waitrequest === 1'b0) begin
         if (rd_q.size() == 0) begin
            fail("read with no note");
         end else begin
            compare_read(rd_q.pop_front(), readdata);
         end
         if (static_chk && address === ADDR_STATUS) begin
            compare_read('{1, 32'h3, {30'h0, input_active, pin_out}, {30'h0, input_active, pin_out}},
               readdata);
         end
      end
      if (cycle_done === 1'b1 && cyc_q.size() != 0) begin
         compare_cycle(cyc_q.pop_front());
      end
   end
   // ********************************
   // Drivers
   // ********************************
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic bus_access(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      @(posedge clock);
      address <= a;
      writedata <= wd;
      write <= wr;
      read <= ~wr;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (waitrequest === 1'b0) break;
      end
      write <= 1'b0;
      read <= 1'b0;
      if (n == 50) begin
         fail("bus answer missing");
         end_of_test();
      end
   endtask
   task automatic bus_read(input logic [3:0] a, input int sh, input logic [31:0] mk,
      input int lo, input int hi);
      rd_q.push_back('{sh, mk, 32'(lo), 32'(hi)});
      bus_access(1'b0, a, 32'h00000000);
   endtask
   task automatic wait_cycles(input int n);
      int k;
      for (k = 0; k < 40000 && n > 0; k++) begin
         @(posedge clock);
         if (cycle_done === 1'b1) n--;
      end
      if (n > 0) begin
         fail("output cycle missing");
         end_of_test();
      end
   endtask
   task automatic run(input int on_t, input int off_t, input int plo, input int phi,
      input int rip);
      wait_cycles(2);
      bus_read(ADDR_STATUS, STAT_PERIOD_LSB, 32'hFFFFFF, plo, phi);
      bus_read(ADDR_STATUS, STAT_RIPPLE_BIT, 32'h1, rip, rip);
      cyc_q.push_back('{on_t, off_t});
      cyc_q.push_back('{on_t, off_t});
      wait_cycles(2);
      $display("test cycle %0d/%0d done", on_t, off_t);
   endtask
   function automatic logic [31:0] ctrl(input int p, input int pl, input int oe);
      return 32'(p) | (32'(pl) << CTRL_POL_BIT) | (32'h1 << CTRL_LOGIC_BIT)
         | (32'(oe) << CTRL_OUT_BIT);
   endfunction
   // ********************************
   // Sequence
   // ********************************
   initial begin
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      bus_read(ADDR_CTRL, 0, 32'hFFFFFFFF, 0, 0);
      bus_read(ADDR_PULSE, 0, 32'hFFFFFFFF, 0, 0);
      bus_read(ADDR_DEMAND, 0, 32'hFFFFFFFF, 0, 0);
      bus_access(1'b1, ADDR_CTRL, ctrl(32'h3FF, 0, 1));
      bus_read(ADDR_CTRL, 0, 32'hFFFFFFFF, 32'h00060258, 32'h00060258);
      bus_access(1'b1, ADDR_DEMAND, 32'h0000007F);
      bus_read(ADDR_DEMAND, 0, 32'h7F, 100, 100);
      bus_access(1'b1, 4'h2, 32'hFFFFFFFF);
      bus_read(4'h2, 0, 32'hFFFFFFFF, 0, 0);
      $display("test registers done");
      bus_access(1'b1, ADDR_PULSE, 32'(M));
      bus_access(1'b1, ADDR_CTRL, ctrl(0, 0, 1));
      bus_access(1'b1, ADDR_DEMAND, 32'd50);
      run(10, 10, 4 * M, 4 * M, 1);
      bus_access(1'b1, ADDR_DEMAND, 32'd20);
      run(6, 25, 31, 31, 1);
      bus_access(1'b1, ADDR_DEMAND, 32'd80);
      run(25, 6, 31, 31, 1);
      bus_access(1'b1, ADDR_CTRL, ctrl(1, 0, 1));
      repeat (2) begin
         d = 20 + ($unsigned($random(seed)) % 61);
         bus_access(1'b1, ADDR_DEMAND, 32'(d));
         run(d, 100 - d, 100, 100, 0);
      end
      bus_access(1'b1, ADDR_DEMAND, 32'd2);
      run(M, 245, 240, 250, 0);
      // Long low-demand cycle must run out before new settings apply
      bus_access(1'b1, ADDR_CTRL, ctrl(0, 0, 1));
      bus_access(1'b1, ADDR_DEMAND, 32'd0);
      repeat (260 * TK) @(posedge clock);
      static_chk <= 1'b1;
      for (pol = 0; pol < 2; pol++) begin
         for (d = 0; d <= 100; d += 100) begin
            bus_access(1'b1, ADDR_CTRL, ctrl(0, pol, 1));
            bus_access(1'b1, ADDR_DEMAND, 32'(d));
            // The design rechecks a steady demand once per least pulse
            repeat (6 * M * TK) @(posedge clock);
            bus_read(ADDR_STATUS, 0, 32'h3, ((d / 100) ^ pol) * 2 + d / 100,
               ((d / 100) ^ pol) * 2 + d / 100);
            in_range("pin enable", {31'h0, pin_oe}, 1, 1);
         end
      end
      $display("test polarity done");
      drive_en <= 1'b1;
      for (pol = 0; pol < 2; pol++) begin
         bus_access(1'b1, ADDR_CTRL, ctrl(0, pol, 0));
         for (lvl = 0; lvl < 2; lvl++) begin
            drive_level <= lvl[0];
            repeat (4) @(posedge clock);
            bus_read(ADDR_STATUS, 1, 32'h3, (lvl ^ pol) * 2, (lvl ^ pol) * 2);
            in_range("input sense", {31'h0, input_active}, lvl ^ pol, lvl ^ pol);
            in_range("pin enable", {31'h0, pin_oe}, 0, 0);
         end
      end
      $display("test digital input done");
      end_of_test();
   end
endmodule
